// >>> core/adc_seq_params.svh
// constants for the converter sequencer and watchdog
// assumes inclusion by bare name from core sources
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define RES_W 12
`define CH_W 5
`define CH_COUNT 19
`define EXT_CH_COUNT 16
`define THERMAL_CH 5'h10
`define BANDGAP_CH 5'h11
`define BATTERY_CH 5'h12
`define TRIM_W 16
`define TRIM_THERMAL_LOW_ADDR 32'h1FFFF7B8
`define TRIM_BANDGAP_ADDR 32'h1FFFF7BA
`define TRIM_THERMAL_HIGH_ADDR 32'h1FFFF7C2
`define BUF_DEPTH 2
`define BUF_PTR_W 1
`define CH_ZERO 5'h00
`define RES_ZERO 12'h000
`define MASK_ZERO 19'h00000
`define MASK_ONE 19'h00001
`define TRIM_ZERO 16'h0000
`endif

// >>> core/adc_seq_pkg.sv
// types shared by the converter sequencer files
// assumes adc_seq_params.svh is on the include path
`default_nettype none
`include "adc_seq_params.svh"
package adc_seq_pkg;
   typedef logic [`RES_W-1:0] code_t;
   typedef logic [`CH_W-1:0] chan_t;
   typedef logic [`CH_COUNT-1:0] chmask_t;
   // one finished result with its channel
   typedef struct packed {
      chan_t chan;
      code_t code;
      logic last;
   } result_t;
   typedef enum logic [1:0] {
      WDG_OFF = 2'b00,
      WDG_SINGLE = 2'b01,
      WDG_SUBSET = 2'b10,
      WDG_ALL = 2'b11
   } wdg_mode_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CONV = 2'b01,
      SEQ_PUSH = 2'b10
   } seq_state_t;
endpackage
`default_nettype wire

// >>> core/result_buffer.sv
// two-entry result buffer between sequencer and dma request
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_params.svh"
module result_buffer (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire adc_seq_pkg::result_t in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output adc_seq_pkg::result_t out_data_o
);
   import adc_seq_pkg::*;
   result_t mem_reg [`BUF_DEPTH];
   logic [`BUF_PTR_W-1:0] wr_ptr_reg;
   logic [`BUF_PTR_W-1:0] rd_ptr_reg;
   logic [`BUF_PTR_W:0] count_reg;
   logic push;
   logic pop;

   // accept while fewer than two entries are held
   assign in_ready_o = (count_reg < 2'(`BUF_DEPTH));
   assign out_valid_o = (count_reg != 2'h0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage has no reset; contents gated by count
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // read data registered from the head entry
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         out_data_o <= '0;
      end else begin
         out_data_o <= mem_reg[rd_ptr_reg];
         if (pop) begin
            out_data_o <= mem_reg[rd_ptr_reg + 1'b1];
         end
         if (push && (count_reg == 2'h0 || (count_reg == 2'h1 && pop))) begin
            out_data_o <= in_data_i;
         end
      end
   end

   // pointers and occupancy
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + 2'(push) - 2'(pop);
      end
   end
endmodule
`default_nettype wire

// >>> core/adc_sequencer_watchdog.sv
// sequencer, channel map, dma hand-off and analog watchdog
// assumes the analog core answers each start with one done, held until accepted
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_params.svh"
// Function
// - results are 12-bit unsigned codes
// - sixteen external plus three internal channels
// - single-shot and scan modes
// - scan converts whole group automatically
// - dma request per result, dma collects
// - watchdog on one, subset, all channels
// - interrupt when result outside window
// - channel 16 is thermal sensor
// - channel 17 is bandgap reference
// - channel 18 is halved battery voltage
// - thermal trims held read-only at addresses
// - bandgap trim held read-only at address
module adc_sequencer_watchdog (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // software configuration
   input wire logic scan_mode_i,
   input wire adc_seq_pkg::chmask_t group_mask_i,
   input wire adc_seq_pkg::chan_t single_chan_i,
   input wire logic trigger_i,
   // watchdog configuration
   input wire adc_seq_pkg::wdg_mode_t wdg_mode_i,
   input wire adc_seq_pkg::chan_t wdg_chan_i,
   input wire adc_seq_pkg::chmask_t wdg_mask_i,
   input wire adc_seq_pkg::code_t wdg_low_i,
   input wire adc_seq_pkg::code_t wdg_high_i,
   // analog core
   output logic conv_start_o,
   output adc_seq_pkg::chan_t conv_chan_o,
   input wire logic conv_done_i,
   input wire adc_seq_pkg::code_t conv_code_i,
   // analog mux selects toward internal sources
   output logic thermal_channel_sel_o,
   output logic bandgap_channel_sel_o,
   output logic battery_channel_sel_o,
   // dma side
   output logic dma_req_o,
   input wire logic dma_ack_i,
   output adc_seq_pkg::result_t dma_data_o,
   // events
   output logic eoc_o,
   output logic eos_o,
   output logic wdg_irq_o,
   output logic busy_o,
   // factory trim read port
   input wire logic [31:0] trim_addr_i,
   output logic [`TRIM_W-1:0] trim_data_o
);
   import adc_seq_pkg::*;

   parameter logic [`TRIM_W-1:0] THERMAL_TRIM_LOW = 16'h0000; // arbitrary factory value
   parameter logic [`TRIM_W-1:0] THERMAL_TRIM_HIGH = 16'h0000; // arbitrary factory value
   parameter logic [`TRIM_W-1:0] BANDGAP_TRIM = 16'h0000; // arbitrary factory value

   ////////////////////////////////////////////////////////////////////
   seq_state_t state_reg;
   chan_t chan_reg;
   chmask_t pending_reg;
   logic last_reg;
   logic buf_in_valid;
   logic buf_in_ready;
   result_t buf_in;
   chmask_t remaining;
   chan_t next_chan;
   logic next_found;
   logic [`CH_COUNT-1:0] lower_set;

   // priority pick of lowest pending channel, one generate loop
   genvar gi;
   generate
      for (gi = 0; gi < `CH_COUNT; gi++) begin : g_pick
         if (gi == 0) begin : g_first
            assign lower_set[gi] = 1'b0;
         end else begin : g_rest
            assign lower_set[gi] = lower_set[gi-1] | remaining[gi-1];
         end
      end
   endgenerate

   // encode the first pending channel
   always_comb begin
      next_chan = `CH_ZERO;
      next_found = 1'b0;
      for (int i = 0; i < `CH_COUNT; i++) begin
         if (remaining[i] && !lower_set[i]) begin
            next_chan = `CH_W'(i);
            next_found = 1'b1;
         end
      end
   end

   // channels still to convert after the current one
   assign remaining = pending_reg;

   ////////////////////////////////////////////////////////////////////
   // sequencer state; a full buffer stalls the next start
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_reg <= SEQ_IDLE;
         chan_reg <= `CH_ZERO;
         pending_reg <= `MASK_ZERO;
         last_reg <= 1'b0;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               if (trigger_i) begin
                  if (scan_mode_i) begin
                     // whole group queued at once, no software between
                     pending_reg <= group_mask_i;
                     if (group_mask_i != `MASK_ZERO) begin
                        state_reg <= SEQ_PUSH;
                        last_reg <= 1'b0;
                     end
                  end else if (single_chan_i < `CH_W'(`CH_COUNT)) begin
                     chan_reg <= single_chan_i; // single-shot
                     last_reg <= 1'b1;
                     pending_reg <= `MASK_ZERO;
                     state_reg <= SEQ_CONV;
                  end
               end
            end
            SEQ_PUSH: begin
               // pick the next group member
               if (next_found) begin
                  chan_reg <= next_chan;
                  pending_reg[next_chan] <= 1'b0;
                  last_reg <= ((remaining & ~(`MASK_ONE << next_chan)) == `MASK_ZERO);
                  state_reg <= SEQ_CONV;
               end else begin
                  state_reg <= SEQ_IDLE;
               end
            end
            SEQ_CONV: begin
               // the analog core holds done, so a full buffer simply waits
               if (conv_done_i && buf_in_ready) begin
                  state_reg <= last_reg ? SEQ_IDLE : SEQ_PUSH;
               end
            end
            default: state_reg <= SEQ_IDLE;
         endcase
      end
   end

   // start pulse on entry to conversion
   logic started_reg;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         started_reg <= 1'b0;
      end else begin
         started_reg <= (state_reg == SEQ_CONV) && !(conv_done_i && buf_in_ready);
      end
   end
   assign conv_start_o = (state_reg == SEQ_CONV) && !started_reg;
   assign conv_chan_o = chan_reg;
   assign busy_o = (state_reg != SEQ_IDLE);

   // internal source routing
   assign thermal_channel_sel_o = (chan_reg == `THERMAL_CH) && busy_o;
   assign bandgap_channel_sel_o = (chan_reg == `BANDGAP_CH) && busy_o;
   assign battery_channel_sel_o = (chan_reg == `BATTERY_CH) && busy_o;

   ////////////////////////////////////////////////////////////////////
   // result handed to the buffer; analog core holds done until ready
   assign buf_in_valid = (state_reg == SEQ_CONV) && conv_done_i;
   assign buf_in.chan = chan_reg;
   assign buf_in.code = conv_code_i; // 12-bit unsigned
   assign buf_in.last = last_reg;

   // per-result dma request through the buffer
   result_buffer u_buf (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(buf_in),
      .out_valid_o(dma_req_o),
      .out_ready_i(dma_ack_i),
      .out_data_o(dma_data_o)
   );

   ////////////////////////////////////////////////////////////////////
   logic accepted;
   logic monitored;
   logic outside;
   assign accepted = buf_in_valid && buf_in_ready;

   // which channels the watchdog looks at
   always_comb begin
      case (wdg_mode_i)
         WDG_SINGLE: monitored = (chan_reg == wdg_chan_i);
         WDG_SUBSET: monitored = wdg_mask_i[chan_reg];
         WDG_ALL: monitored = 1'b1;
         default: monitored = 1'b0;
      endcase
   end

   // equal to a threshold counts as inside
   assign outside = (conv_code_i < wdg_low_i) || (conv_code_i > wdg_high_i);

   // registered event pulses
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         eoc_o <= 1'b0;
         eos_o <= 1'b0;
         wdg_irq_o <= 1'b0;
      end else begin
         eoc_o <= accepted;
         eos_o <= accepted && last_reg;
         wdg_irq_o <= accepted && monitored && outside;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read-only factory trims, halfword per address
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         trim_data_o <= `TRIM_ZERO;
      end else begin
         case (trim_addr_i)
            `TRIM_THERMAL_LOW_ADDR: trim_data_o <= THERMAL_TRIM_LOW;
            `TRIM_THERMAL_HIGH_ADDR: trim_data_o <= THERMAL_TRIM_HIGH;
            `TRIM_BANDGAP_ADDR: trim_data_o <= BANDGAP_TRIM;
            default: trim_data_o <= `TRIM_ZERO;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> tb/adc_seq_sva.sv
// port checker for the sequencer: starts, pulses, dma hold, channel selects
// assumes binding onto adc_sequencer_watchdog, single clock, sync reset
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_params.svh"
module adc_seq_sva (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // watched inputs
   input wire logic scan_mode_i,
   input wire logic trigger_i,
   input wire adc_seq_pkg::chmask_t group_mask_i,
   input wire logic conv_done_i,
   input wire logic dma_ack_i,
   // watched outputs
   input wire logic conv_start_o,
   input wire adc_seq_pkg::chan_t conv_chan_o,
   input wire logic thermal_channel_sel_o,
   input wire logic bandgap_channel_sel_o,
   input wire logic battery_channel_sel_o,
   input wire logic dma_req_o,
   input wire adc_seq_pkg::result_t dma_data_o,
   input wire logic eoc_o,
   input wire logic eos_o,
   input wire logic wdg_irq_o,
   input wire logic busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // trigger taken from idle, then one start pulse
   sequence s_single_trig;
      !busy_o && trigger_i && !scan_mode_i;
   endsequence
   sequence s_scan_trig;
      !busy_o && trigger_i && scan_mode_i && group_mask_i != 19'h00000;
   endsequence
   sequence s_one_start;
      conv_start_o ##1 !conv_start_o;
   endsequence
   AST_SINGLE_START: assert property (s_single_trig |=> s_one_start)
      else $error("single trigger gave no start pulse");
   AST_SCAN_START: assert property (s_scan_trig |-> ##2 s_one_start)
      else $error("scan trigger gave no start pulse");
   // a pending request keeps its word until the dma takes it
   AST_DMA_HOLD: assert property (
         dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_data_o))
      else $error("dma request dropped or data moved");
   AST_THERMAL_SEL: assert property (
         thermal_channel_sel_o |-> busy_o && conv_chan_o == `THERMAL_CH)
      else $error("thermal select off its channel");
   AST_BANDGAP_SEL: assert property (
         bandgap_channel_sel_o |-> busy_o && conv_chan_o == `BANDGAP_CH)
      else $error("bandgap select off its channel");
   AST_BATTERY_SEL: assert property (
         battery_channel_sel_o |-> busy_o && conv_chan_o == `BATTERY_CH)
      else $error("battery select off its channel");
   AST_EOC_CAUSE: assert property (eoc_o |-> $past(conv_done_i) && dma_req_o)
      else $error("end of conversion without result");
   AST_EOS_PAIR: assert property (eos_o |-> eoc_o)
      else $error("end of sequence without end of conversion");
   AST_IRQ_CAUSE: assert property (wdg_irq_o |-> eoc_o)
      else $error("watchdog pulse without a result");
endmodule
bind adc_sequencer_watchdog adc_seq_sva u_adc_seq_sva (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .scan_mode_i(scan_mode_i), .trigger_i(trigger_i), .group_mask_i(group_mask_i),
   .conv_done_i(conv_done_i), .dma_ack_i(dma_ack_i), .conv_start_o(conv_start_o),
   .conv_chan_o(conv_chan_o), .thermal_channel_sel_o(thermal_channel_sel_o),
   .bandgap_channel_sel_o(bandgap_channel_sel_o), .battery_channel_sel_o(battery_channel_sel_o),
   .dma_req_o(dma_req_o), .dma_data_o(dma_data_o), .eoc_o(eoc_o), .eos_o(eos_o),
   .wdg_irq_o(wdg_irq_o), .busy_o(busy_o));
`default_nettype wire

// >>> tb/analog_core_model.sv
// behavioural analog core: answers each start with one held done
// assumes the sequencer signals acceptance with its end-of-conversion pulse
`timescale 1ns/1ns
`default_nettype none
module analog_core_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // speed and sequencer side
   input wire logic slow_i,
   input wire logic conv_start_i,
   input wire adc_seq_pkg::chan_t conv_chan_i,
   input wire logic eoc_i,
   output logic conv_done_o,
   output adc_seq_pkg::code_t conv_code_o
);
   import adc_seq_pkg::*;
   int wait_reg;
   // done holds through a stall; code flips when released, never stale
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wait_reg <= 0;
         conv_done_o <= 1'b0;
         conv_code_o <= 12'hA5A;
      end else if (conv_start_i) begin
         wait_reg <= slow_i ? 9 : 2;
      end else if (wait_reg == 1) begin
         wait_reg <= 0;
         conv_done_o <= 1'b1;
         conv_code_o <= {1'b0, conv_chan_i, 6'h15};
      end else if (wait_reg > 1) begin
         wait_reg <= wait_reg - 1;
      end else if (eoc_i && conv_done_o) begin
         conv_done_o <= 1'b0;
         conv_code_o <= ~conv_code_o;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the sequencer, dma hand-off and watchdog
// assumes the analog core model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
   import adc_seq_pkg::*;
   logic ref_clk_i, reset_i, scan_mode, trigger, conv_start, conv_done, slow;
   logic dma_req, dma_ack, eoc, eos, irq, busy, th_sel, bg_sel, bat_sel;
   chmask_t group_mask, wdg_mask;
   chan_t single_chan, wdg_chan, conv_chan;
   wdg_mode_t wdg_mode;
   code_t wdg_low, wdg_high, conv_code;
   result_t dma_data;
   logic [31:0] trim_addr;
   logic [15:0] trim_data;
   int mismatches = 0;
   int check_count = 0;
   adc_sequencer_watchdog #(.THERMAL_TRIM_LOW(16'h1A2B), .THERMAL_TRIM_HIGH(16'h3C4D),
      .BANDGAP_TRIM(16'h5E6F)) u_adc_sequencer_watchdog (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .scan_mode_i(scan_mode), .group_mask_i(group_mask),
      .single_chan_i(single_chan), .trigger_i(trigger), .wdg_mode_i(wdg_mode),
      .wdg_chan_i(wdg_chan), .wdg_mask_i(wdg_mask), .wdg_low_i(wdg_low), .wdg_high_i(wdg_high),
      .conv_start_o(conv_start), .conv_chan_o(conv_chan), .conv_done_i(conv_done),
      .conv_code_i(conv_code), .thermal_channel_sel_o(th_sel), .bandgap_channel_sel_o(bg_sel),
      .battery_channel_sel_o(bat_sel), .dma_req_o(dma_req), .dma_ack_i(dma_ack),
      .dma_data_o(dma_data), .eoc_o(eoc), .eos_o(eos), .wdg_irq_o(irq), .busy_o(busy),
      .trim_addr_i(trim_addr), .trim_data_o(trim_data));
   analog_core_model u_analog_core_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .slow_i(slow), .conv_start_i(conv_start), .conv_chan_i(conv_chan), .eoc_i(eoc),
      .conv_done_o(conv_done), .conv_code_o(conv_code));
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one dma collection, settled at the following falling edge
   task automatic pop;
      @(posedge ref_clk_i) dma_ack <= 1'b1;
      @(posedge ref_clk_i) dma_ack <= 1'b0;
      @(negedge ref_clk_i);
   endtask
   // single shot; trigger held a second edge, which must be ignored
   task automatic run_one(input chan_t ch, output result_t r, output logic [2:0] ev,
                          output logic [2:0] sel);
      ev = 3'b000;
      sel = 3'b000;
      @(posedge ref_clk_i);
      scan_mode <= 1'b0;
      single_chan <= ch;
      trigger <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      trigger <= 1'b0;
      for (int n = 0; n < 60 && ev[2] !== 1'b1; n++) begin
         @(negedge ref_clk_i);
         ev |= {eoc, eos, irq};
         sel |= {th_sel, bg_sel, bat_sel};
      end
      r = dma_data;
      `CHK(dma_req, 1'b1)
      pop();
   endtask
   task automatic t_single;
      chan_t chans [5] = '{5'h00, 5'h0F, `THERMAL_CH, `BANDGAP_CH, `BATTERY_CH};
      result_t r;
      logic [2:0] ev, sel;
      slow <= 1'b1;
      foreach (chans[i]) begin
         run_one(chans[i], r, ev, sel);
         `CHK(r, {chans[i], 1'b0, chans[i], 6'h15, 1'b1})
         `CHK(ev[2:1], 2'b11)
         `CHK(sel, {chans[i] == 5'h10, chans[i] == 5'h11, chans[i] == 5'h12})
      end
      repeat (20) @(negedge ref_clk_i);
      `CHK(dma_req, 1'b0)
   endtask
   // scan with the dma stalled: buffer fills, sequencer waits, nothing lost
   task automatic t_scan;
      chan_t chans [4] = '{5'h01, 5'h03, `THERMAL_CH, `BATTERY_CH};
      @(posedge ref_clk_i);
      slow <= 1'b0;
      scan_mode <= 1'b1;
      group_mask <= 19'h5000A;
      trigger <= 1'b1;
      @(posedge ref_clk_i) trigger <= 1'b0;
      repeat (80) @(negedge ref_clk_i);
      `CHK(busy, 1'b1)
      foreach (chans[i]) begin
         for (int n = 0; n < 60 && dma_req !== 1'b1; n++) @(negedge ref_clk_i);
         `CHK(dma_data, {chans[i], 1'b0, chans[i], 6'h15, i == 3})
         pop();
      end
   endtask
   // reset in mid-scan with two results waiting: idle, buffer and pulses cleared
   task automatic t_reset;
      @(posedge ref_clk_i);
      scan_mode <= 1'b1;
      group_mask <= 19'h0000E;
      trigger <= 1'b1;
      @(posedge ref_clk_i) trigger <= 1'b0;
      repeat (12) @(negedge ref_clk_i);
      `CHK({busy, dma_req}, 2'b11)
      @(posedge ref_clk_i) reset_i <= 1'b1;
      @(posedge ref_clk_i) reset_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK({busy, dma_req, eoc, eos, irq}, 5'h00)
   endtask
   task automatic t_trim;
      logic [31:0] a [3] = '{`TRIM_THERMAL_LOW_ADDR, `TRIM_THERMAL_HIGH_ADDR, `TRIM_BANDGAP_ADDR};
      logic [15:0] v [3] = '{16'h1A2B, 16'h3C4D, 16'h5E6F};
      foreach (a[i]) begin
         @(posedge ref_clk_i) trim_addr <= a[i];
         @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         `CHK(trim_data, v[i])
      end
   endtask
   // channel 2 converts to 12'h095
   task automatic t_wdg(input wdg_mode_t m, input chan_t c, input chmask_t k, input code_t lo,
                        input code_t hi, input logic exp);
      result_t r;
      logic [2:0] ev, sel;
      @(posedge ref_clk_i);
      wdg_mode <= m;
      wdg_chan <= c;
      wdg_mask <= k;
      wdg_low <= lo;
      wdg_high <= hi;
      run_one(5'h02, r, ev, sel);
      `CHK(ev[0], exp)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {reset_i, scan_mode, trigger, slow, dma_ack} = 5'h10;
      {group_mask, wdg_mask, single_chan, wdg_chan, trim_addr} = '0;
      wdg_mode = WDG_OFF;
      wdg_low = 12'h000;
      wdg_high = 12'hFFF;
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_single();
      t_scan();
      t_reset();
      t_trim();
      t_wdg(WDG_OFF, 5'h00, 19'h00000, 12'h100, 12'hFFF, 1'b0);
      t_wdg(WDG_ALL, 5'h00, 19'h00000, 12'h095, 12'h095, 1'b0);
      t_wdg(WDG_ALL, 5'h00, 19'h00000, 12'h096, 12'hFFF, 1'b1);
      t_wdg(WDG_ALL, 5'h00, 19'h00000, 12'h000, 12'h094, 1'b1);
      t_wdg(WDG_SINGLE, 5'h02, 19'h00000, 12'h096, 12'hFFF, 1'b1);
      t_wdg(WDG_SINGLE, 5'h03, 19'h00000, 12'h096, 12'hFFF, 1'b0);
      t_wdg(WDG_SUBSET, 5'h00, 19'h00004, 12'h096, 12'hFFF, 1'b1);
      t_wdg(WDG_SUBSET, 5'h00, 19'h00008, 12'h096, 12'hFFF, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
